/* verilog/hwd_defs.vh */
`ifndef HWD_DEFS_VH
`define HWD_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define HWD_OFF_WDT_CTRL   12'h000
`define HWD_OFF_RST_FLAGS  12'h004
`define HWD_OFF_CLK_CFG    12'h008
`define HWD_OFF_STATUS     12'h00c
`define HWD_OFF_WAKE_MASK  12'h010
`define HWD_OFF_IRQ_STAT   12'h014
`define HWD_OFF_IRQ_CLR    12'h018
`define HWD_OFF_IRQ_EN     12'h01c
// ----------------------------------------
// Reset value and valid key codes
// ----------------------------------------
`define HWD_WDT_CTRL_RST   8'h53
`define HWD_KEY_GOOD_A     5'h0a
`define HWD_KEY_GOOD_B     5'h15
// ----------------------------------------
// Field positions
// ----------------------------------------
`define HWD_KEY_MSB        7
`define HWD_KEY_LSB        3
`define HWD_SEL_MSB        2
`define HWD_SEL_LSB        0
`define HWD_CFG_SUB_KEEP   0
`define HWD_CFG_HIGH_KEEP  1
`define HWD_RF_SOFT        0
`define HWD_RF_LOWV        2
`define HWD_ST_PDF         0
`define HWD_ST_TO          1
`define HWD_IRQ_WAKE       0
`define HWD_IRQ_TIMEOUT    1
`define HWD_IRQ_SOFTRST    2
// ----------------------------------------
// Timing
// ----------------------------------------
`define HWD_CLK_NS         20
`define HWD_SRESET_NS      2000
`define HWD_SRESET_CYC     (`HWD_SRESET_NS / `HWD_CLK_NS)
// Slow ticks per period minus one, one per period select code
`define HWD_LIM_SEL0       18'h000ff
`define HWD_LIM_SEL1       18'h003ff
`define HWD_LIM_SEL2       18'h00fff
`define HWD_LIM_SEL3       18'h03fff
`define HWD_LIM_SEL4       18'h07fff
`define HWD_LIM_SEL5       18'h0ffff
`define HWD_LIM_SEL6       18'h1ffff
`define HWD_LIM_SEL7       18'h3ffff
`endif

/* verilog/hwd_watchdog.v */
// Operation
// - Halt with keeps 0/1: high clock off
// - Halt with keeps 1/1: both clocks run
// - Halt with keeps 1/0: sub clock off
// - Idle entry: set powerdown, clear timeout, clear counter
// - Wake on port edge, interrupt, watchdog overflow
// - Powerdown flag cleared by power-up or clear instruction
// - Overflow in power-down: wake, timeout set, PC/SP reset
// - Per-pin wake enable, resume after halt
// - Disabled or stack full: resume, hold pending
// - Enabled, stack free: immediate interrupt response
// - Flag already set before halt cannot wake
// - Watchdog counts only slow oscillator edges
// - Key 01010 or 10101 enables, else reset
// - Invalid key: delayed reset, soft flag set
// - Period select gives 2^8 to 2^18 ticks
// - Soft flag survives reset, software clears only
// - Halt with keeps 0/0: sleep, all clocks off
// - Overflow when running: full reset, timeout set
`timescale 1ns/1ps
`include "hwd_defs.vh"

module hwd_watchdog #(
   parameter PA_W        = 8,
   parameter INT_N       = 4,
   parameter SRESET_CYC  = `HWD_SRESET_CYC
) (
   // Clock, reset, enable
   input  wire              clk,
   input  wire              srst,
   input  wire              ce,
   // APB slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   // Core side
   input  wire              haltInstr,
   input  wire              clrWdtInstr,
   input  wire [INT_N-1:0]  intReq,
   input  wire [INT_N-1:0]  intEnable,
   input  wire              stackFull,
   // Pins and slow oscillator
   input  wire [PA_W-1:0]   portAPin,
   input  wire              slowOscClk,
   // Control outputs
   output reg               highClkEn,
   output reg               subClkEn,
   output reg               coreHalted,
   output reg               wakeResume,
   output reg  [INT_N-1:0]  intService,
   output reg  [INT_N-1:0]  intPending,
   output reg               pcSpReset,
   output reg               deviceReset,
   output reg               powerdownFlag,
   output reg               watchdogTimeoutFlag,
   output reg               irq
);

   // ----------------------------------------
   // Modes
   // ----------------------------------------
   localparam RUN   = 5'b00001;
   localparam SLEEP = 5'b00010;
   localparam IDLE_SUB  = 5'b00100;
   localparam IDLE_BOTH = 5'b01000;
   localparam IDLE_HIGH = 5'b10000;

   reg  [4:0]        mode_reg;
   reg  [4:0]        mode_next;
   reg  [7:0]        wdtCtrl_reg;
   reg               softFlag_reg;
   reg               lowvFlag_reg;
   reg  [1:0]        clkCfg_reg;
   reg  [PA_W-1:0]   wakeMask_reg;
   reg  [2:0]        irqStat_reg;
   reg  [2:0]        irqEn_reg;
   reg  [17:0]       wdtCnt_reg;
   reg  [15:0]       srCnt_reg;
   reg  [INT_N-1:0]  armMask_reg;
   reg  [PA_W-1:0]   paS1_reg;
   reg  [PA_W-1:0]   paS2_reg;
   reg  [PA_W-1:0]   paS3_reg;
   reg  [2:0]        oscSync_reg;
   reg  [17:0]       limit;
   reg  [2:0]        irqSet;

   wire              wr;
   wire              rd;
   wire              mapped;
   wire [4:0]        wdtKey;
   wire              keyOk;
   wire              oscTick;
   wire              overflow;
   wire              asleep;
   wire [PA_W-1:0]   paFall;
   wire              pinWake;
   wire [INT_N-1:0]  intWake;
   wire              wakeAny;
   wire              halting;
   wire              softFire;
   wire [INT_N-1:0]  canServe;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign wr = psel & penable & ~pready & pwrite;
   assign rd = psel & penable & ~pready & ~pwrite;
   assign mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);

   // ----------------------------------------
   // Decoded conditions
   // ----------------------------------------
   assign wdtKey = wdtCtrl_reg[`HWD_KEY_MSB:`HWD_KEY_LSB];
   assign keyOk = (wdtKey == `HWD_KEY_GOOD_A) || (wdtKey == `HWD_KEY_GOOD_B);
   // Slow oscillator rising edge, from the second sync stage on
   assign oscTick = oscSync_reg[1] & ~oscSync_reg[2];
   assign overflow = keyOk & oscTick & (wdtCnt_reg == limit);
   assign asleep = ~mode_reg[0];
   // Falling edges seen after the synchroniser
   assign paFall = paS3_reg & ~paS2_reg;
   assign pinWake = |(paFall & wakeMask_reg);
   // Only requests not already set at halt may wake
   assign intWake = intReq & armMask_reg;
   assign wakeAny = asleep & (pinWake | (|intWake) | overflow);
   assign halting = mode_reg[0] & haltInstr;
   // Delay expired on an invalid key
   assign softFire = ~keyOk & (srCnt_reg == SRESET_CYC[15:0] - 16'h0001);
   assign canServe = intEnable & {INT_N{~stackFull}};

   // ----------------------------------------
   // Period limit
   // ----------------------------------------
   // Ticks per period minus one
   always @* begin
      case (wdtCtrl_reg[`HWD_SEL_MSB:`HWD_SEL_LSB])
         3'h0:    limit = `HWD_LIM_SEL0;
         3'h1:    limit = `HWD_LIM_SEL1;
         3'h2:    limit = `HWD_LIM_SEL2;
         3'h3:    limit = `HWD_LIM_SEL3;
         3'h4:    limit = `HWD_LIM_SEL4;
         3'h5:    limit = `HWD_LIM_SEL5;
         3'h6:    limit = `HWD_LIM_SEL6;
         default: limit = `HWD_LIM_SEL7;
      endcase
   end

   // ----------------------------------------
   // Mode selection
   // ----------------------------------------
   always @* begin
      mode_next = mode_reg;
      case (mode_reg)
         RUN: begin
            if (haltInstr) begin
               case (clkCfg_reg)
                  2'b00:   mode_next = SLEEP;
                  2'b01:   mode_next = IDLE_SUB;
                  2'b10:   mode_next = IDLE_HIGH;
                  default: mode_next = IDLE_BOTH;
               endcase
            end
         end
         SLEEP, IDLE_SUB, IDLE_BOTH, IDLE_HIGH: begin
            if (wakeAny) begin
               mode_next = RUN;
            end
         end
         default: mode_next = RUN;
      endcase
      if (softFire) begin
         mode_next = RUN;
      end
   end

   // ----------------------------------------
   // Mode and clock gates
   // ----------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         mode_reg <= RUN;
         highClkEn <= 1'b1;
         subClkEn <= 1'b1;
         coreHalted <= 1'b0;
      end else if (ce) begin
         mode_reg <= mode_next;
         highClkEn <= mode_next[0] | mode_next[3] | mode_next[4];
         subClkEn <= mode_next[0] | mode_next[2] | mode_next[3];
         coreHalted <= ~mode_next[0];
      end
   end

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         paS1_reg <= {PA_W{1'b1}};
         paS2_reg <= {PA_W{1'b1}};
         paS3_reg <= {PA_W{1'b1}};
         oscSync_reg <= 3'h0;
      end else if (ce) begin
         paS1_reg <= portAPin;
         paS2_reg <= paS1_reg;
         paS3_reg <= paS2_reg;
         oscSync_reg <= {oscSync_reg[1:0], slowOscClk};
      end
   end

   // ----------------------------------------
   // Watchdog counter and soft reset delay
   // ----------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         wdtCnt_reg <= 18'h00000;
         srCnt_reg <= 16'h0000;
      end else if (ce) begin
         // Cleared on halt, by the clear instruction, on overflow, or while the key is bad
         if (halting | clrWdtInstr | overflow | ~keyOk) begin
            wdtCnt_reg <= 18'h00000;
         end else if (oscTick) begin
            wdtCnt_reg <= wdtCnt_reg + 18'h00001;
         end
         // Count the delay while the key is bad
         if (keyOk | softFire) begin
            srCnt_reg <= 16'h0000;
         end else begin
            srCnt_reg <= srCnt_reg + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Flags and reset outputs
   // ----------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         powerdownFlag <= 1'b0;
         watchdogTimeoutFlag <= 1'b0;
         pcSpReset <= 1'b0;
         deviceReset <= 1'b0;
         wakeResume <= 1'b0;
         armMask_reg <= {INT_N{1'b0}};
      end else if (ce) begin
         // Overflow in power-down resets PC and SP only
         pcSpReset <= asleep & overflow;
         // Full reset on running overflow or bad key
         deviceReset <= (~asleep & overflow) | softFire;
         // Resume after halt on pin or interrupt wake
         wakeResume <= wakeAny & ~overflow;
         // Cleared by reset or by the clear instruction
         if (halting) begin
            powerdownFlag <= 1'b1;
         end else if (clrWdtInstr) begin
            powerdownFlag <= 1'b0;
         end
         // Overflow sets timeout, halt clears it
         if (overflow) begin
            watchdogTimeoutFlag <= 1'b1;
         end else if (halting) begin
            watchdogTimeoutFlag <= 1'b0;
         end
         // Snapshot of requests clear at halt
         if (halting) begin
            armMask_reg <= ~intReq;
         end
      end
   end

   // ----------------------------------------
   // Interrupt wake response per source
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < INT_N; g = g + 1) begin : gInt
         always @(posedge clk) begin
            if (srst) begin
               intService[g] <= 1'b0;
               intPending[g] <= 1'b0;
            end else if (ce) begin
               intService[g] <= 1'b0;
               if (wakeAny & intWake[g]) begin
                  if (canServe[g]) begin
                     intService[g] <= 1'b1;
                  end else begin
                     intPending[g] <= 1'b1;
                  end
               end else if (intPending[g] & canServe[g]) begin
                  // Serve once enabled or stack frees
                  intService[g] <= 1'b1;
                  intPending[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         wdtCtrl_reg <= `HWD_WDT_CTRL_RST;
         softFlag_reg <= 1'b0;
         lowvFlag_reg <= 1'b0;
         clkCfg_reg <= 2'b00;
         wakeMask_reg <= {PA_W{1'b0}};
         irqEn_reg <= 3'h0;
      end else if (ce) begin
         if (wr && mapped && paddr == `HWD_OFF_WDT_CTRL) begin
            wdtCtrl_reg <= pwdata[7:0];
         end else if (softFire) begin
            // Soft reset on a bad key restores the default key and period
            wdtCtrl_reg <= `HWD_WDT_CTRL_RST;
         end
         if (wr && mapped && paddr == `HWD_OFF_RST_FLAGS) begin
            lowvFlag_reg <= pwdata[`HWD_RF_LOWV];
         end
         // Hardware sets, software alone clears, set wins
         if (softFire) begin
            softFlag_reg <= 1'b1;
         end else if (wr && mapped && paddr == `HWD_OFF_RST_FLAGS) begin
            softFlag_reg <= pwdata[`HWD_RF_SOFT];
         end
         if (wr && mapped && paddr == `HWD_OFF_CLK_CFG) begin
            clkCfg_reg <= pwdata[1:0];
         end
         if (wr && mapped && paddr == `HWD_OFF_WAKE_MASK) begin
            wakeMask_reg <= pwdata[PA_W-1:0];
         end
         if (wr && mapped && paddr == `HWD_OFF_IRQ_EN) begin
            irqEn_reg <= pwdata[2:0];
         end
      end
   end

   // ----------------------------------------
   // Event status and interrupt line
   // ----------------------------------------
   always @* begin
      irqSet = 3'h0;
      irqSet[`HWD_IRQ_WAKE] = wakeAny;
      irqSet[`HWD_IRQ_TIMEOUT] = overflow;
      irqSet[`HWD_IRQ_SOFTRST] = softFire;
   end

   always @(posedge clk) begin
      if (srst) begin
         irqStat_reg <= 3'h0;
         irq <= 1'b0;
      end else if (ce) begin
         // Set wins over a clear in the same cycle
         if (wr && mapped && paddr == `HWD_OFF_IRQ_CLR) begin
            irqStat_reg <= (irqStat_reg & ~pwdata[2:0]) | irqSet;
         end else begin
            irqStat_reg <= irqStat_reg | irqSet;
         end
         irq <= |((irqStat_reg | irqSet) & irqEn_reg);
      end
   end

   // ----------------------------------------
   // APB answer, one wait state
   // ----------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata <= 32'h00000000;
         if (rd && mapped) begin
            case (paddr)
               `HWD_OFF_WDT_CTRL:  prdata <= {24'h000000, wdtCtrl_reg};
               `HWD_OFF_RST_FLAGS: prdata <= {29'h0, lowvFlag_reg, 1'b0, softFlag_reg};
               `HWD_OFF_CLK_CFG:   prdata <= {30'h0, clkCfg_reg};
               `HWD_OFF_STATUS:    prdata <= {25'h0, mode_reg, watchdogTimeoutFlag,
                                              powerdownFlag};
               `HWD_OFF_WAKE_MASK: prdata <= {{(32-PA_W){1'b0}}, wakeMask_reg};
               `HWD_OFF_IRQ_STAT:  prdata <= {29'h0, irqStat_reg};
               `HWD_OFF_IRQ_EN:    prdata <= {29'h0, irqEn_reg};
               default:            prdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

/* bench/hwd_watchdog_chk.sv */
`timescale 1ns/1ps
module hwd_watchdog_chk #(
   parameter INT_N = 4
) (
   // Clock and reset
   input wire             clk,
   input wire             srst,
   // Bus handshake
   input wire             psel,
   input wire             penable,
   input wire             pready,
   input wire             pslverr,
   // Core side
   input wire             clrWdtInstr,
   input wire             stackFull,
   input wire [INT_N-1:0] intEnable,
   input wire [INT_N-1:0] intService,
   // Control outputs
   input wire             highClkEn,
   input wire             subClkEn,
   input wire             coreHalted,
   input wire             wakeResume,
   input wire             pcSpReset,
   input wire             deviceReset,
   input wire             powerdownFlag,
   input wire             watchdogTimeoutFlag
);
   // ------
   // Checks
   // ------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Bus answers only an access phase
   chk_ready_access: assert property (pready |-> $past(psel && penable))
      else $error("pready outside access");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_entry_flags: assert property ($rose(coreHalted) |-> ##[0:1]
      (powerdownFlag && !watchdogTimeoutFlag)) else $error("idle entry flags");
   chk_run_clocks: assert property ($fell(coreHalted) |-> ##[0:1]
      (highClkEn && subClkEn)) else $error("clocks off after wake");
   chk_gate_halted: assert property ((!highClkEn || !subClkEn) |->
      (coreHalted || $past(coreHalted))) else $error("clock gated in run");
   chk_powerdown_clear: assert property ($fell(powerdownFlag) |-> $past(clrWdtInstr))
      else $error("powerdown flag cleared without clear");
   chk_ovf_flag: assert property (pcSpReset |-> ##[0:1] watchdogTimeoutFlag)
      else $error("timeout flag not set");
   chk_ovf_asleep: assert property (pcSpReset |->
      ($past(coreHalted) && !deviceReset)) else $error("partial reset while running");
   chk_wake_halt: assert property (wakeResume |->
      ($past(coreHalted) || $past(coreHalted, 2))) else $error("resume without halt");
   chk_serve_enabled: assert property (|intService |->
      (((intService & ~$past(intEnable)) == '0) && !$past(stackFull)))
      else $error("service of disabled interrupt");
   cover property ($rose(coreHalted));
   cover property (pcSpReset);
   cover property (|intService);
endmodule

bind hwd_watchdog hwd_watchdog_chk #(.INT_N(INT_N)) u_chk (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .clrWdtInstr(clrWdtInstr), .stackFull(stackFull),
   .intEnable(intEnable), .intService(intService), .highClkEn(highClkEn),
   .subClkEn(subClkEn), .coreHalted(coreHalted), .wakeResume(wakeResume),
   .pcSpReset(pcSpReset), .deviceReset(deviceReset), .powerdownFlag(powerdownFlag),
   .watchdogTimeoutFlag(watchdogTimeoutFlag));

/* bench/hwd_watchdog_tb.sv */
`timescale 1ns/1ps
`include "hwd_defs.vh"
module hwd_watchdog_tb;
   // Stimulus and observed signals
   reg         clk, srst, psel, penable, pwrite, haltInstr, clrWdtInstr, stackFull, errb;
   reg         ceIn;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [3:0]  intReq, intEnable;
   reg  [7:0]  portAPin;
   reg  [1:0]  oscDiv;
   wire [31:0] prdata;
   wire [3:0]  intService, intPending;
   wire        pready, pslverr, highClkEn, subClkEn, coreHalted, wakeResume, irq;
   wire        pcSpReset, deviceReset, powerdownFlag, watchdogTimeoutFlag;
   integer     err_count, tests_run, n, i;
   // Slow oscillator, one tick per four cycles
   wire        slowOscClk = oscDiv[1];

   hwd_watchdog #(.SRESET_CYC(12)) uut (
      .clk(clk), .srst(srst), .ce(ceIn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .haltInstr(haltInstr),
      .clrWdtInstr(clrWdtInstr), .intReq(intReq), .intEnable(intEnable),
      .stackFull(stackFull), .portAPin(portAPin), .slowOscClk(slowOscClk),
      .highClkEn(highClkEn), .subClkEn(subClkEn), .coreHalted(coreHalted),
      .wakeResume(wakeResume), .intService(intService), .intPending(intPending),
      .pcSpReset(pcSpReset), .deviceReset(deviceReset), .powerdownFlag(powerdownFlag),
      .watchdogTimeoutFlag(watchdogTimeoutFlag), .irq(irq));

   // -------
   // Helpers
   // -------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) oscDiv <= oscDiv + 2'd1;

   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (exp !== got) begin
            err_count = err_count + 1;
            $display("FAIL %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   // Bus cycle, held until pready is sampled high
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         n = 0;
         psel   <= 1'b1;
         pwrite <= w;
         paddr  <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge clk);
         end
         chk("bus ready", 32'h1, pready);
         rd = prdata;
         errb = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge clk);
      end
   endtask

   function logic probe(input integer k);
      case (k)
         0: probe = wakeResume;
         1: probe = intService[0];
         2: probe = pcSpReset;
         default: probe = deviceReset;
      endcase
   endfunction

   task waitp(input integer k, input integer lim);
      begin
         n = 0;
         while (probe(k) !== 1'b1 && n < lim) begin
            n = n + 1;
            @(posedge clk);
         end
      end
   endtask

   task halt;
      begin
         haltInstr <= 1'b1;
         @(posedge clk);
         haltInstr <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask

   task clear_watchdog_instr;
      begin
         clrWdtInstr <= 1'b1;
         @(posedge clk);
         clrWdtInstr <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask

   task wrap_up;
      begin
         if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask

   // ---------
   // Scenarios
   // ---------
   task t_regs;
      begin
         apb(1'b0, `HWD_OFF_WDT_CTRL, 32'h0);
         chk("ctrl reset", 32'h53, rd);
         apb(1'b0, `HWD_OFF_RST_FLAGS, 32'h0);
         chk("soft flag", 32'h0, rd & 32'h1);
         apb(1'b0, 12'h040, 32'h0);
         chk("unmapped", 32'h1, errb);
      end
   endtask

   task t_ce;
      begin
         ceIn <= 1'b0;
         haltInstr <= 1'b1;
         @(posedge clk);
         haltInstr <= 1'b0;
         repeat (3) @(posedge clk);
         ceIn <= 1'b1;
         repeat (2) @(posedge clk);
         chk("ce freeze", 32'h0, {coreHalted, powerdownFlag});
      end
   endtask

   task t_modes;
      begin
         apb(1'b1, `HWD_OFF_WAKE_MASK, 32'h1);
         apb(1'b1, `HWD_OFF_IRQ_EN, 32'h1);
         for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, `HWD_OFF_CLK_CFG, i);
            halt;
            chk("high clk", i[1], highClkEn);
            chk("sub clk", i[0], subClkEn);
            chk("powerdown set", 32'h3, {coreHalted, powerdownFlag});
            portAPin <= 8'hfe;
            waitp(0, 40);
            chk("pin wake", 32'h1, wakeResume);
            repeat (3) @(posedge clk);
            chk("powerdown kept", 32'h1, {coreHalted, powerdownFlag});
            portAPin <= 8'hff;
            clear_watchdog_instr;
            chk("powerdown clr", 32'h0, powerdownFlag);
         end
         chk("irq", 32'h1, irq);
         apb(1'b1, `HWD_OFF_IRQ_EN, 32'h0);
         chk("irq mask", 32'h0, irq);
         apb(1'b1, `HWD_OFF_IRQ_CLR, 32'h7);
         apb(1'b1, `HWD_OFF_IRQ_EN, 32'h1);
         chk("irq clr", 32'h0, irq);
      end
   endtask

   task t_int;
      begin
         apb(1'b1, `HWD_OFF_CLK_CFG, 32'h3);
         intReq <= 4'h1;
         halt;
         portAPin <= 8'hfd;
         repeat (12) @(posedge clk);
         chk("no early wake", 32'h1, coreHalted);
         portAPin <= 8'hfc;
         waitp(0, 40);
         chk("masked pin wake", 32'h1, wakeResume);
         portAPin <= 8'hff;
         intReq <= 4'h0;
         intEnable <= 4'h1;
         repeat (4) @(posedge clk);
         halt;
         intReq <= 4'h1;
         waitp(1, 30);
         chk("service", 32'h1, intService[0]);
         intReq <= 4'h0;
         intEnable <= 4'h0;
         repeat (4) @(posedge clk);
         halt;
         intReq <= 4'h1;
         waitp(0, 30);
         chk("int wake", 32'h1, wakeResume);
         repeat (3) @(posedge clk);
         chk("pending", 32'h1, intPending[0]);
         intEnable <= 4'h1;
         waitp(1, 30);
         chk("late service", 32'h1, intService[0]);
         intReq <= 4'h0;
         stackFull <= 1'b1;
         repeat (4) @(posedge clk);
         halt;
         intReq <= 4'h1;
         waitp(0, 30);
         repeat (2) @(posedge clk);
         chk("stack full hold", 32'h1, {intService[0], intPending[0]});
         stackFull <= 1'b0;
         waitp(1, 30);
         chk("stack free service", 32'h1, intService[0]);
         intReq <= 4'h0;
      end
   endtask

   task t_period;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            apb(1'b1, `HWD_OFF_WDT_CTRL, 32'h50 | i);
            clear_watchdog_instr;
            waitp(3, 20000);
            chk("period", 32'h1, n >= (1024 << (2 * i)) - 8 && n <= (1024 << (2 * i)) + 24);
            repeat (2) @(posedge clk);
            chk("run timeout", 32'h1, watchdogTimeoutFlag);
         end
         apb(1'b1, `HWD_OFF_WDT_CTRL, 32'h50);
         apb(1'b1, `HWD_OFF_CLK_CFG, 32'h0);
         halt;
         chk("timeout cleared", 32'h0, watchdogTimeoutFlag);
         waitp(2, 1200);
         chk("sleep ovf", 32'h1, {deviceReset, pcSpReset});
         repeat (2) @(posedge clk);
         chk("timeout set", 32'h3, {watchdogTimeoutFlag, powerdownFlag});
         clear_watchdog_instr;
      end
   endtask

   task t_key;
      begin
         apb(1'b1, `HWD_OFF_WDT_CTRL, 32'hab);
         waitp(3, 30);
         chk("good key", 32'h0, deviceReset);
         apb(1'b1, `HWD_OFF_WDT_CTRL, 32'h03);
         waitp(3, 40);
         chk("bad key", 32'h1, deviceReset && n >= 8 && n <= 14);
         repeat (2) @(posedge clk);
         apb(1'b0, `HWD_OFF_RST_FLAGS, 32'h0);
         chk("soft set", 32'h1, rd & 32'h1);
         apb(1'b0, `HWD_OFF_IRQ_STAT, 32'h0);
         chk("soft event", 32'h4, rd & 32'h4);
         apb(1'b0, `HWD_OFF_WDT_CTRL, 32'h0);
         chk("ctrl reload", 32'h53, rd);
         apb(1'b1, `HWD_OFF_RST_FLAGS, 32'h0);
         apb(1'b0, `HWD_OFF_RST_FLAGS, 32'h0);
         chk("soft clr", 32'h0, rd & 32'h1);
      end
   endtask

   initial begin
      #1_200_000;
      err_count = err_count + 1;
      wrap_up;
   end

   initial begin
      {srst, psel, penable, pwrite, haltInstr, clrWdtInstr, stackFull} = 7'h40;
      {paddr, pwdata, intReq, intEnable, oscDiv} = '0;
      portAPin = 8'hff;
      ceIn = 1'b1;
      err_count = 0;
      tests_run = 0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_ce;
      t_modes;
      t_int;
      t_period;
      t_key;
      wrap_up;
   end
endmodule
